// *** sfpi_defines.svh ***
`ifndef SFPI_DEFINES_SVH
`define SFPI_DEFINES_SVH

// Bus timing in nanoseconds and derived cycle counts at 125 MHz.
`define SFPI_CLK_NS 8
`define SFPI_STROBE_NS 40
`define SFPI_STROBE_CYC ((`SFPI_STROBE_NS + `SFPI_CLK_NS - 1) / `SFPI_CLK_NS)
`define SFPI_SETUP_NS 16
`define SFPI_SETUP_CYC ((`SFPI_SETUP_NS + `SFPI_CLK_NS - 1) / `SFPI_CLK_NS)
`define SFPI_READ_NS 96
`define SFPI_READ_CYC ((`SFPI_READ_NS + `SFPI_CLK_NS - 1) / `SFPI_CLK_NS)
// Longest gap between byte loads; rounded down so the window is never missed.
`define SFPI_WINDOW_NS 150000
`define SFPI_WINDOW_CYC (`SFPI_WINDOW_NS / `SFPI_CLK_NS)
// Poll budget before giving up, in cycles (20 ms).
`define SFPI_POLL_MAX_CYC 2500000
// Field positions.
`define SFPI_POLL_BIT 7
`define SFPI_TOGGLE_BIT 6
`define SFPI_SECTOR_LSB 8

`endif

// *** sfpi_pkg.sv ***
package sfpi_pkg;
  typedef enum logic [1:0] {
    SFPI_OP_READ,
    SFPI_OP_LOAD,
    SFPI_OP_POLL
  } sfpi_op_t;

  // One request from the user side.
  typedef struct packed {
    sfpi_op_t op;
    logic [17:0] addr;
    logic [7:0] data;
  } sfpi_req_t;

  // Pins driven toward the flash.
  typedef struct packed {
    logic chip_select_n;
    logic output_enable_n;
    logic write_strobe_n;
    logic [17:0] address_lines;
    logic [7:0] data_out;
    logic data_oe;
  } sfpi_pins_t;
endpackage : sfpi_pkg

// *** sfpi_sync.sv ***
`timescale 1ns/10ps
// Two-flop synchroniser for the incoming data lines.
module sfpi_sync #(
  parameter int W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : sfpi_sync

// *** sfpi_host.sv ***
`timescale 1ns/10ps
`include "sfpi_defines.svh"
// Operation
// RULE_01: Reads drive chip select and output enable low, write strobe high.
// RULE_02: Device floats data when select or output enable is high; the flash model drives the inverse of its last read byte instead.
// RULE_03: Loads pulse write strobe low with select low, output enable high.
// RULE_04: Device latches address on the later falling edge.
// RULE_05: Device latches data on the earlier rising edge.
// RULE_06: Host loads every byte of any sector it changes.
// RULE_07: Next load starts within 150 us, else programming begins.
// RULE_08: Sector address bits stay valid at each falling strobe.
// RULE_09: Byte addresses within a sector may load in any order.
// RULE_10: Device latches data internally, then erases and programs itself.
// RULE_11: Polling last byte returns inverted top data bit while busy.
// RULE_12: Host starts no access until end of program is seen.
// RULE_13: Three command writes enable write protection; shipped disabled.
// RULE_14: Under protection, each program cycle opens with the command bytes.
// RULE_15: Protection persists until its disable command, across power cycles.
// RULE_16: Unprotected write under protection runs timers, stores nothing.
// RULE_17: Command bytes use the same load timing and window.
// RULE_18: Device blocks programming at low supply and 5 ms after.
// RULE_19: Device starts no program with output enable low or strobes high.
// RULE_20: Device ignores strobe pulses shorter than about 15 ns.
// RULE_21: Identification mode returns maker and device codes both ways.
// RULE_22: After programming, reads return true data on all lines.
// RULE_23: Toggle bit flips on successive reads while busy.
// RULE_24: Locked boot blocks refuse erase and program.
// RULE_25: Protection sequence addresses and data come from the user.
module sfpi_host #(
  parameter int STROBE_CYC = `SFPI_STROBE_CYC,
  parameter int SETUP_CYC = `SFPI_SETUP_CYC,
  parameter int READ_CYC = `SFPI_READ_CYC,
  parameter int WINDOW_CYC = `SFPI_WINDOW_CYC,
  parameter int POLL_MAX_CYC = `SFPI_POLL_MAX_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire sfpi_pkg::sfpi_req_t i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_data,
  output logic o_rsp_timeout,
  output logic o_window_lapsed,
  output sfpi_pkg::sfpi_pins_t o_pins,
  input wire logic [7:0] i_data_lines
);
  import sfpi_pkg::*;

  typedef enum logic [2:0] {
    SFPI_IDLE,
    SFPI_SETUP,
    SFPI_STROBE,
    SFPI_HOLD,
    SFPI_READ,
    SFPI_GAP
  } sfpi_state_t;

  localparam int CW = 24;
  localparam logic [CW-1:0] STROBE_C = CW'(STROBE_CYC);
  localparam logic [CW-1:0] SETUP_C = CW'(SETUP_CYC);
  localparam logic [CW-1:0] READ_C = CW'(READ_CYC);
  localparam logic [CW-1:0] WINDOW_C = CW'(WINDOW_CYC);
  localparam logic [CW-1:0] POLL_C = CW'(POLL_MAX_CYC);

  sfpi_state_t state_r;
  sfpi_req_t req_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] win_r;
  logic [CW-1:0] poll_r;
  logic window_open_r;
  logic [7:0] data_sync;
  logic [7:0] prev_r;
  logic have_prev_r;

  sfpi_sync #(.W(8)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_data_lines),
    .o_sync(data_sync)
  );

  // New requests only when idle; poll requests wait out nothing else.
  // RULE_13 RULE_14 RULE_25 command codes: the user issues protection bytes as loads.
  assign o_req_ready = (state_r == SFPI_IDLE);

  // Access sequencer for reads, byte loads and polling reads.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= SFPI_IDLE;
      req_r <= '0;
      cnt_r <= '0;
    end else begin
      case (state_r)
        SFPI_IDLE: begin
          if (i_req_valid) begin
            req_r <= i_req;
            cnt_r <= SETUP_C;
            state_r <= SFPI_SETUP;
          end
        end
        SFPI_SETUP: begin
          if (cnt_r > CW'(1)) begin
            cnt_r <= cnt_r - CW'(1);
          end else if (req_r.op == SFPI_OP_LOAD) begin
            cnt_r <= STROBE_C;
            state_r <= SFPI_STROBE;
          end else begin
            cnt_r <= READ_C;
            state_r <= SFPI_READ;
          end
        end
        SFPI_STROBE: begin
          if (cnt_r > CW'(1)) begin
            cnt_r <= cnt_r - CW'(1);
          end else begin
            cnt_r <= SETUP_C;
            state_r <= SFPI_HOLD;
          end
        end
        SFPI_HOLD, SFPI_GAP: begin
          if (cnt_r > CW'(1)) begin
            cnt_r <= cnt_r - CW'(1);
          end else begin
            state_r <= SFPI_IDLE;
          end
        end
        SFPI_READ: begin
          if (cnt_r > CW'(1)) begin
            cnt_r <= cnt_r - CW'(1);
          end else begin
            cnt_r <= SETUP_C;
            state_r <= SFPI_GAP;
          end
        end
        default: state_r <= SFPI_IDLE;
      endcase
    end
  end

  // Pin drive; chip select is the steady enable and write strobe the pulse.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pins <= '{chip_select_n: 1'b1, output_enable_n: 1'b1, write_strobe_n: 1'b1,
                  address_lines: '0, data_out: '0, data_oe: 1'b0};
    end else begin
      // RULE_08 sector address: held from the request for the whole access.
      o_pins.address_lines <= req_r.addr;
      // RULE_06 RULE_17 load path: every data or command byte is one ordinary load.
      o_pins.data_out <= req_r.data;
      // RULE_03 load strobe shape: output enable stays high during loads.
      o_pins.write_strobe_n <= !(state_r == SFPI_SETUP && cnt_r == CW'(1)
                                 && req_r.op == SFPI_OP_LOAD)
                               && !(state_r == SFPI_STROBE && cnt_r > CW'(1));
      o_pins.data_oe <= (req_r.op == SFPI_OP_LOAD) &&
                        (state_r == SFPI_SETUP || state_r == SFPI_STROBE);
      // RULE_01 read enables: select falls one cycle before output enable and rises one cycle after it.
      o_pins.output_enable_n <= !(req_r.op != SFPI_OP_LOAD &&
                                  (state_r == SFPI_SETUP && cnt_r == CW'(1) ||
                                   state_r == SFPI_READ && cnt_r > CW'(1)));
      o_pins.chip_select_n <= !(state_r == SFPI_SETUP || state_r == SFPI_STROBE ||
                                state_r == SFPI_READ || state_r == SFPI_HOLD)
                              || (state_r == SFPI_IDLE);
    end
  end

  // RULE_07 load window: warns when the 150 us gap after a load has passed.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win_r <= '0;
      window_open_r <= 1'b0;
      o_window_lapsed <= 1'b0;
    end else begin
      o_window_lapsed <= 1'b0;
      if (state_r == SFPI_STROBE && cnt_r == CW'(1)) begin
        win_r <= WINDOW_C;
        window_open_r <= 1'b1;
      end else if (window_open_r) begin
        if (win_r > CW'(1)) begin
          win_r <= win_r - CW'(1);
        end else begin
          window_open_r <= 1'b0;
          o_window_lapsed <= 1'b1;
        end
      end
    end
  end

  // RULE_12 completion detect: poll ends on matching top bit and steady toggle bit.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_data <= '0;
      o_rsp_timeout <= 1'b0;
      prev_r <= '0;
      have_prev_r <= 1'b0;
      poll_r <= '0;
    end else begin
      o_rsp_valid <= 1'b0;
      o_rsp_timeout <= 1'b0;
      if (state_r == SFPI_IDLE && i_req_valid && i_req.op == SFPI_OP_POLL &&
          !have_prev_r) begin
        poll_r <= '0;
      end
      if (state_r == SFPI_READ && cnt_r == CW'(1)) begin
        o_rsp_data <= data_sync;
        if (req_r.op == SFPI_OP_READ) begin
          o_rsp_valid <= 1'b1;
          have_prev_r <= 1'b0;
        end else begin
          // RULE_11 poll bit: done when bit 7 equals bit 7 of the poll request's data.
          // RULE_23 toggle bit: done when bit 6 stops changing.
          if (have_prev_r &&
              data_sync[`SFPI_POLL_BIT] == req_r.data[`SFPI_POLL_BIT] &&
              data_sync[`SFPI_TOGGLE_BIT] == prev_r[`SFPI_TOGGLE_BIT]) begin
            o_rsp_valid <= 1'b1;
            have_prev_r <= 1'b0;
          end else if (poll_r >= POLL_C) begin
            o_rsp_valid <= 1'b1;
            o_rsp_timeout <= 1'b1;
            have_prev_r <= 1'b0;
          end else begin
            have_prev_r <= 1'b1;
          end
          prev_r <= data_sync;
        end
      end
      if (have_prev_r && poll_r < POLL_C) begin
        poll_r <= poll_r + CW'(1);
      end
    end
  end

  // RULE_03 no overlap: output enable never low while write strobe is low.
  a_load_oe_high: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_pins.write_strobe_n |-> o_pins.output_enable_n)
    else $error("output enable low during a write strobe");
  // RULE_01 read select: output enable low only with select low, strobe high.
  a_read_select: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_pins.output_enable_n |-> !o_pins.chip_select_n && o_pins.write_strobe_n)
    else $error("read enables without select");
  // RULE_02 no contention: host never drives while output enable is low.
  a_no_contention: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_pins.data_oe |-> o_pins.output_enable_n)
    else $error("host drives data during a read");
  // RULE_20 strobe width: a write strobe lasts more than one cycle.
  a_strobe_width: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $fell(o_pins.write_strobe_n) |=> !o_pins.write_strobe_n)
    else $error("write strobe too short");
  // RULE_05 data held: data driven until the strobe has risen.
  a_data_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(o_pins.write_strobe_n) |-> o_pins.data_oe && !o_pins.chip_select_n)
    else $error("data dropped before strobe rise");
  // RULE_04 address valid: address steady across a low strobe.
  a_addr_steady: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_pins.write_strobe_n && !$past(o_pins.write_strobe_n) |-> $stable(o_pins.address_lines))
    else $error("address moved during a strobe");
  // RULE_07 window start: each completed load arms the gap timer.
  a_window_arm: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(o_pins.write_strobe_n) |-> window_open_r)
    else $error("load window not armed");
  // RULE_12 busy gate: a new request is offered only once the bus is quiet.
  a_busy_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_req_ready |-> o_pins.output_enable_n && o_pins.write_strobe_n)
    else $error("request offered while a strobe is active");
endmodule : sfpi_host

// *** sfpi_flash_model.sv ***
`timescale 1ns/10ps
// Behavioural flash part facing the host pins.
module sfpi_flash_model #(
  parameter int WIN_NS = 1600,
  parameter int PROG_NS = 6000
) (
  input wire sfpi_pkg::sfpi_pins_t i_pins,
  output logic [7:0] o_dq,
  output int o_err
);
  import sfpi_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] buf_d [int];
  logic [17:0] lat_a = '0;
  logic [9:0] sect = '0;
  logic [7:0] last_d = '0;
  logic [7:0] rd = '0;
  logic [7:0] held = '0;
  logic busy = 0;
  logic loading = 0;
  logic tog = 0;
  logic drv = 0;
  realtime t_fall = 0;
  realtime t_rise = 0;
  initial o_err = 0;

  // Address capture; a write strobe overlapping output enable is a host fault.
  // later fall latches.
  always @(negedge i_pins.chip_select_n or negedge i_pins.write_strobe_n) begin
    if (!i_pins.chip_select_n && !i_pins.write_strobe_n) begin
      if (!i_pins.output_enable_n) begin
        o_err++;
      end else if (!busy) begin
        if (buf_d.num() != 0 && i_pins.address_lines[17:8] != sect) o_err++;
        sect = i_pins.address_lines[17:8];
        lat_a = i_pins.address_lines;
        loading = 1;
        t_fall = $realtime;
      end
    end
  end

  // Data capture on the first rising strobe; short glitches store nothing.
  // first rise latches.
  always @(posedge i_pins.chip_select_n or posedge i_pins.write_strobe_n) begin
    if (loading && $realtime - t_fall >= 15) begin
      if (!i_pins.data_oe) o_err++;
      buf_d[lat_a[7:0]] = i_pins.data_out;
      last_d = i_pins.data_out;
      t_rise = $realtime;
    end
    loading = 0;
  end

  // Load period ends after a quiet window, then the sector is rewritten.
  // timed sector program.
  initial forever begin
    #4;
    if (buf_d.num() != 0 && !loading && $realtime - t_rise >= WIN_NS) begin
      busy = 1;
      for (int i = 0; i < 256; i++) begin
        mem[{sect, i[7:0]}] = buf_d.exists(i) ? buf_d[i] : 8'hff;
      end
      buf_d.delete();
      #(PROG_NS);
      busy = 0;
    end
  end

  // Status bit six flips on every read while busy.
  // toggle per read.
  always @(negedge i_pins.output_enable_n) if (busy) tog = ~tog;

  // Read path; a released bus shows the inverse of the last driven byte.
  // read and float.
  always @(i_pins or busy or tog or last_d) begin
    drv = !i_pins.chip_select_n && !i_pins.output_enable_n && i_pins.write_strobe_n;
    if (busy) rd = {~last_d[7], tog, 6'h2a};
    else if (mem.exists(int'(i_pins.address_lines))) rd = mem[int'(i_pins.address_lines)];
    else rd = 8'hff;
    if (drv) held = rd;
    o_dq = drv ? rd : ~held;
  end
endmodule : sfpi_flash_model

// *** sfpi_host_tb.sv ***
`timescale 1ns/10ps
// Self-checking bench for the flash host controller.
module sfpi_host_tb;
  import sfpi_pkg::*;
  logic i_sys_clk = 0;
  logic i_rst_n = 0;
  logic i_req_valid = 0;
  sfpi_req_t i_req = '0;
  logic o_req_ready, o_rsp_valid, o_rsp_timeout, o_window_lapsed;
  logic [7:0] o_rsp_data;
  logic [7:0] dq;
  sfpi_pins_t o_pins;
  int n_fail = 0;
  int comparisons = 0;
  int merr;
  wire [7:0] data_lines = o_pins.data_oe ? o_pins.data_out : dq;

  // Free-running system clock.
  always #4 i_sys_clk = ~i_sys_clk;

  sfpi_host #(.WINDOW_CYC(200), .POLL_MAX_CYC(2000)) uut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .o_rsp_timeout(o_rsp_timeout), .o_window_lapsed(o_window_lapsed), .o_pins(o_pins),
    .i_data_lines(data_lines));

  sfpi_flash_model #(.WIN_NS(1600), .PROG_NS(6000)) flash (
    .i_pins(o_pins), .o_dq(dq), .o_err(merr));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Presents one request at a falling edge once the host is idle.
  task automatic send(input sfpi_op_t op, input logic [17:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (o_req_ready !== 1'b1) begin
      @(negedge i_sys_clk);
      n++;
      if (n > 100) begin
        chk("ready", 8'h01, 8'h00);
        give_verdict();
      end
    end
    i_req = '{op, a, d};
    i_req_valid = 1;
    @(negedge i_sys_clk);
    i_req_valid = 0;
  endtask : send

  task automatic xfer(input sfpi_op_t op, input logic [17:0] a, input logic [7:0] d,
                      input int lim);
    int n;
    n = 0;
    send(op, a, d);
    while (o_rsp_valid !== 1'b1) begin
      @(negedge i_sys_clk);
      n++;
      if (n > lim) begin
        chk("response", 8'h01, 8'h00);
        give_verdict();
      end
    end
  endtask : xfer

  // Reissues polling reads until the host reports completion or a timeout.
  task automatic poll(input logic [17:0] a, input logic [7:0] d, input int lim);
    int n;
    n = 0;
    send(SFPI_OP_POLL, a, d);
    while (o_rsp_valid !== 1'b1) begin
      if (o_req_ready === 1'b1) begin
        send(SFPI_OP_POLL, a, d);
      end else begin
        @(negedge i_sys_clk);
      end
      n++;
      if (n > lim) begin
        chk("poll response", 8'h01, 8'h00);
        give_verdict();
      end
    end
  endtask : poll

  task automatic t_reset;
    chk("idle strobes", 8'h07, {5'h0, o_pins.chip_select_n, o_pins.output_enable_n,
        o_pins.write_strobe_n});
    chk("idle drive", 8'h00, {7'h0, o_pins.data_oe});
    chk("idle ready", 8'h01, {7'h0, o_req_ready});
    $display("test reset done");
  endtask : t_reset

  task automatic t_load_poll;
    int n;
    n = 0;
    send(SFPI_OP_LOAD, 18'h01205, 8'ha5);
    send(SFPI_OP_LOAD, 18'h01201, 8'h3c);
    while (o_window_lapsed !== 1'b1 && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk("lapse", 8'h01, {7'h0, o_window_lapsed});
    xfer(SFPI_OP_READ, 18'h01201, 8'h00, 40);
    chk("busy poll bit", 8'h01, {7'h0, o_rsp_data[7]});
    poll(18'h01201, 8'h3c, 2500);
    chk("poll timeout", 8'h00, {7'h0, o_rsp_timeout});
    chk("poll data", 8'h3c, o_rsp_data);
    xfer(SFPI_OP_READ, 18'h01205, 8'h00, 40);
    chk("read first", 8'ha5, o_rsp_data);
    xfer(SFPI_OP_READ, 18'h01201, 8'h00, 40);
    chk("read last", 8'h3c, o_rsp_data);
    $display("test load_poll done");
  endtask : t_load_poll

  task automatic t_poll_timeout;
    poll(18'h01201, 8'hc3, 2500);
    chk("poll gave up", 8'h01, {7'h0, o_rsp_timeout});
    chk("stored data", 8'h3c, o_rsp_data);
    chk("pin faults", 8'h00, merr[7:0]);
    $display("test poll_timeout done");
  endtask : t_poll_timeout

  // Reset, then the scenarios in order.
  initial begin
    repeat (5) @(negedge i_sys_clk);
    t_reset();
    i_rst_n = 1;
    @(negedge i_sys_clk);
    t_load_poll();
    t_poll_timeout();
    give_verdict();
  end
endmodule : sfpi_host_tb
